// ==== hdl/ucf_usb_command.sv ====
// Notes on behaviour
// (R1) threshold field bits 23..16 gives min interrupt interval in microframes; zero immediate
// (R2) interrupts never faster than threshold; pending causes held until threshold point
// (R3) bit 15 is top bit of frame list size, joined with bits 3..2
// (R4) software sets and clears bit 14 while appending descriptor to primed endpoint
// (R5) hardware clears bit 14 on entering the descriptor hazard region
// (R6) software sets and clears bit 13 while copying eight setup bytes
// (R7) with lockout off, new setup during copy makes hardware clear bit 13
// (R8) park enable bit 11 resets to zero, read/write, one enables park
// (R9) software keeps park count 1..3 while park mode enabled
// (R10) software re-reads semaphore after its operation and retries if cleared
// (R11) reserved bits 31..24 and 12 read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none

module ucf_usb_command
   import ucf_pkg::*;
#(
   parameter int MFRAME_CLKS = ucf_pkg::MFRAME_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire ucf_pkg::ucf_bus_s bus,
   output logic [ucf_pkg::DATA_W-1:0] rdata,
   input wire logic desc_hazard,
   input wire logic setup_arrival,
   input wire logic setup_lockout_en,
   input wire logic [ucf_pkg::FLS_LOW_W-1:0] frame_list_size_low,
   input wire logic [ucf_pkg::CAUSE_W-1:0] cause_in,
   output ucf_pkg::ucf_cmd_s cmd,
   output logic [ucf_pkg::FLS_W-1:0] frame_list_size,
   output logic irq
);
   import ucf_pkg::*;

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      ucf_cmd_s cmd;
      logic [DATA_W-1:0] rdata;
      logic irq;
      logic [FLS_W-1:0] fls;
      logic hazard_prev;
      logic [ITC_W-1:0] mf_cnt;
      ucf_thr_e thr;
      logic [EV_W-1:0] mask;
   } ucf_top_s;

   ucf_top_s s_q;
   ucf_top_s s_d;

   logic mf_tick;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] ev_set;
   logic status_clr_we;
   logic desc_ev;
   logic setup_ev;

   // ***************************************************
   // helpers
   // ***************************************************
   // reserved bits stay zero in the word view
   function automatic logic [DATA_W-1:0] cmd_word(input ucf_cmd_s c);
      logic [DATA_W-1:0] w;
      w = '0;
      w[ITC_MSB:ITC_LSB] = c.interrupt_threshold;
      w[FS2_BIT] = c.frame_list_size_high;
      w[DSEM_BIT] = c.descriptor_add_semaphore;
      w[SSEM_BIT] = c.setup_copy_semaphore;
      w[PARK_BIT] = c.park_mode_enable;
      return w; // [R11]
   endfunction

   // ***************************************************
   // submodules
   // ***************************************************
   ucf_tick_div #(
      .CYCLES(MFRAME_CLKS)
   ) u_mframe (
      .clk(clk),
      .rst(rst),
      .tick(mf_tick)
   );

   assign status_clr_we = bus.we && (bus.addr == OFS_STATUS);

   always_comb begin
      ev_set = '0;
      ev_set[EV_CAUSE0] = cause_in[0];
      ev_set[EV_CAUSE1] = cause_in[1];
      ev_set[EV_DESC_HAZARD] = desc_ev;
      ev_set[EV_SETUP_HAZARD] = setup_ev;
   end

   ucf_sticky #(
      .W(EV_W)
   ) u_status (
      .clk(clk),
      .rst(rst),
      .set(ev_set),
      .clr_we(status_clr_we),
      .clr_data(bus.wdata[EV_W-1:0]),
      .flags(status)
   );

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      logic pend;
      logic thr_pt;
      logic [ITC_W:0] cnt_nxt;
      pend = 1'b0;
      thr_pt = 1'b0;
      cnt_nxt = '0;
      s_d = s_q;
      desc_ev = 1'b0;
      setup_ev = 1'b0;

      // software writes; only documented fields are stored
      if (bus.we && (bus.addr == OFS_CMD)) begin
         s_d.cmd.interrupt_threshold = bus.wdata[ITC_MSB:ITC_LSB]; // [R1]
         s_d.cmd.frame_list_size_high = bus.wdata[FS2_BIT]; // [R3]
         s_d.cmd.descriptor_add_semaphore = bus.wdata[DSEM_BIT];
         s_d.cmd.setup_copy_semaphore = bus.wdata[SSEM_BIT];
         s_d.cmd.park_mode_enable = bus.wdata[PARK_BIT]; // [R8]
      end
      if (bus.we && (bus.addr == OFS_MASK)) begin
         s_d.mask = bus.wdata[EV_W-1:0];
      end

      // hardware clear beats a software write in the same cycle,
      // so a hazard is never hidden by a late set
      if (desc_hazard && !s_q.hazard_prev) begin
         desc_ev = s_d.cmd.descriptor_add_semaphore;
         s_d.cmd.descriptor_add_semaphore = 1'b0; // [R5]
      end
      s_d.hazard_prev = desc_hazard;

      if (setup_arrival && !setup_lockout_en) begin
         setup_ev = s_d.cmd.setup_copy_semaphore;
         s_d.cmd.setup_copy_semaphore = 1'b0; // [R7]
      end

      s_d.fls = {s_d.cmd.frame_list_size_high, frame_list_size_low}; // [R3]

      // read data stand only in the cycle after the strobe
      s_d.rdata = '0;
      if (bus.re) begin
         case (bus.addr)
            OFS_CMD: begin
               s_d.rdata = cmd_word(s_q.cmd); // [R11]
            end
            OFS_STATUS: begin
               s_d.rdata[EV_W-1:0] = status;
            end
            OFS_MASK: begin
               s_d.rdata[EV_W-1:0] = s_q.mask;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end

      // free-running microframe phase; threshold points are fixed in
      // time, so a fresh cause never fires sooner than one interval
      // after the previous point
      if (mf_tick) begin
         cnt_nxt = {1'b0, s_q.mf_cnt} + {{ITC_W{1'b0}}, 1'b1};
         if (cnt_nxt >= {1'b0, s_q.cmd.interrupt_threshold}) begin
            thr_pt = 1'b1; // [R1]
            s_d.mf_cnt = '0;
         end else begin
            s_d.mf_cnt = cnt_nxt[ITC_W-1:0];
         end
      end

      pend = |(status & s_q.mask);

      case (s_q.thr)
         THR_IDLE: begin
            if (pend) begin
               if (s_q.cmd.interrupt_threshold == ITC_IMMEDIATE) begin
                  s_d.thr = THR_OPEN; // [R1]
               end else begin
                  s_d.thr = THR_WAIT; // [R2]
               end
            end
         end
         THR_WAIT: begin
            if (!pend) begin
               s_d.thr = THR_IDLE;
            end else if (thr_pt ||
                         s_q.cmd.interrupt_threshold == ITC_IMMEDIATE) begin
               s_d.thr = THR_OPEN; // [R2]
            end
         end
         THR_OPEN: begin
            if (!pend) begin
               s_d.thr = THR_IDLE;
            end
         end
         default: begin
            s_d.thr = THR_IDLE;
         end
      endcase

      s_d.irq = (s_d.thr == THR_OPEN); // [R2]
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q.cmd <= CMD_RESET; // [R8]
         s_q.rdata <= '0;
         s_q.irq <= 1'b0;
         s_q.fls <= '0;
         s_q.hazard_prev <= 1'b0;
         s_q.mf_cnt <= '0;
         s_q.thr <= THR_IDLE;
         s_q.mask <= MASK_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign rdata = s_q.rdata;
   assign cmd = s_q.cmd;
   assign frame_list_size = s_q.fls;
   assign irq = s_q.irq;

endmodule // ucf_usb_command

`default_nettype wire

// ==== hdl/ucf_pkg.sv ====
`default_nettype none

package ucf_pkg;

   // ***************************************************
   // register bus
   // ***************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
      logic re;
   } ucf_bus_s;

   // ***************************************************
   // command register fields
   // ***************************************************
   localparam int ITC_W = 8;
   localparam int ITC_LSB = 16;
   localparam int ITC_MSB = 23;
   localparam int FS2_BIT = 15;
   localparam int DSEM_BIT = 14;
   localparam int SSEM_BIT = 13;
   localparam int PARK_BIT = 11;
   localparam int FLS_W = 3;
   localparam int FLS_LOW_W = 2;
   localparam logic [ITC_W-1:0] ITC_IMMEDIATE = 8'h00;

   typedef struct packed {
      logic [ITC_W-1:0] interrupt_threshold;
      logic frame_list_size_high;
      logic descriptor_add_semaphore;
      logic setup_copy_semaphore;
      logic park_mode_enable;
   } ucf_cmd_s;

   localparam ucf_cmd_s CMD_RESET = '0;

   // ***************************************************
   // interrupt status bits
   // ***************************************************
   localparam int EV_W = 4;
   localparam int CAUSE_W = 2;
   localparam int EV_CAUSE0 = 0;
   localparam int EV_CAUSE1 = 1;
   localparam int EV_DESC_HAZARD = 2;
   localparam int EV_SETUP_HAZARD = 3;
   localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int MFRAME_NS = 125000;
   localparam int MFRAME_CYCLES = MFRAME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      THR_IDLE = 2'b00,
      THR_WAIT = 2'b01,
      THR_OPEN = 2'b10
   } ucf_thr_e;

endpackage

`default_nettype wire

// ==== hdl/ucf_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none

// one-cycle pulse every CYCLES clocks
module ucf_tick_div #(
   parameter int CYCLES = 12500
) (
   input wire logic clk,
   input wire logic rst,
   output logic tick
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } ucf_div_s;

   ucf_div_s s_q;
   ucf_div_s s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == LAST) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule // ucf_tick_div

`default_nettype wire

// ==== hdl/ucf_sticky.sv ====
`timescale 1ns/1ps
`default_nettype none

// sticky flags, write one to clear, set wins over clear
module ucf_sticky #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] set,
   input wire logic clr_we,
   input wire logic [W-1:0] clr_data,
   output logic [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] flags;
   } ucf_stk_s;

   ucf_stk_s s_q;
   ucf_stk_s s_d;

   always_comb begin
      s_d = s_q;
      if (clr_we) begin
         s_d.flags = s_q.flags & ~clr_data;
      end
      s_d.flags = s_d.flags | set;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flags = s_q.flags;
endmodule // ucf_sticky

`default_nettype wire

// ==== test/ucf_usb_command_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucf_usb_command_checker
   import ucf_pkg::*;
#(
   parameter int MFRAME_CLKS = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire ucf_pkg::ucf_bus_s bus,
   input wire logic [ucf_pkg::DATA_W-1:0] rdata,
   input wire logic [ucf_pkg::FLS_LOW_W-1:0] frame_list_size_low,
   input wire ucf_pkg::ucf_cmd_s cmd,
   input wire logic [ucf_pkg::FLS_W-1:0] frame_list_size,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_cmd;
   int gap_q;
   assign wr_cmd = bus.we && bus.addr == OFS_CMD;
   // a new threshold does not restart the phase, so spacing is unknown until the next rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q <= 1 << 20;
      end else if ($changed(cmd.interrupt_threshold)) begin
         gap_q <= 1 << 20;
      end else if ($rose(irq)) begin
         gap_q <= 1;
      end else begin
         gap_q <= gap_q + 1;
      end
   end
   rd_idle_a: assert property (!$past(bus.re) |-> rdata == '0)
      else $error("read data not zero outside read");
   rsvd_zero_a: assert property ($past(bus.re) && $past(bus.addr) == OFS_CMD |->
      rdata[31:24] == 8'h00 && !rdata[12] && rdata[10:0] == 11'h000)
      else $error("reserved command bits not zero");
   thr_write_a: assert property (wr_cmd |=>
      cmd.interrupt_threshold == $past(bus.wdata[ITC_MSB:ITC_LSB]))
      else $error("threshold not written");
   park_write_a: assert property (wr_cmd |=> cmd.park_mode_enable == $past(bus.wdata[PARK_BIT]))
      else $error("park enable not written");
   park_hold_a: assert property (!wr_cmd |=> $stable(cmd.park_mode_enable))
      else $error("park enable changed without write");
   fls_low_a: assert property (frame_list_size[1:0] == $past(frame_list_size_low))
      else $error("frame list size low bits wrong");
   fls_high_a: assert property ($stable(cmd.frame_list_size_high) |->
      frame_list_size[2] == cmd.frame_list_size_high)
      else $error("frame list size top bit wrong");
   irq_gap_a: assert property ($rose(irq) && cmd.interrupt_threshold != 8'h00 |->
      gap_q >= cmd.interrupt_threshold * MFRAME_CLKS)
      else $error("interrupt faster than threshold");
endmodule // ucf_usb_command_checker
`default_nettype wire

// ==== test/ucf_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// controller core: hazard region spans a few cycles, setup arrival is a pulse
module ucf_ctrl_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go_desc,
   input wire logic go_setup,
   output logic desc_hazard,
   output logic setup_arrival
);
   logic [1:0] region_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         region_q <= 2'h0;
         setup_arrival <= 1'b0;
      end else begin
         region_q <= go_desc ? 2'h3 : region_q - {1'b0, region_q != 2'h0};
         setup_arrival <= go_setup;
      end
   end
   assign desc_hazard = region_q != 2'h0;
endmodule // ucf_ctrl_model
`default_nettype wire

// ==== test/ucf_usb_command_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucf_usb_command_tb;
   import ucf_pkg::*;
   localparam int MF = 8;
   logic clk, rst, lock, go_desc, go_setup, hz, sa, irq;
   logic [1:0] fls_low, cause;
   logic [2:0] fls;
   logic [31:0] rdata, got, d;
   ucf_bus_s bus;
   ucf_cmd_s cmd;
   int n_errors = 0;
   int n_tests = 0;
   ucf_usb_command #(.MFRAME_CLKS(MF)) u_ucf_usb_command (.clk(clk), .rst(rst), .bus(bus),
      .rdata(rdata), .desc_hazard(hz), .setup_arrival(sa), .setup_lockout_en(lock),
      .frame_list_size_low(fls_low), .cause_in(cause), .cmd(cmd), .frame_list_size(fls),
      .irq(irq));
   ucf_ctrl_model u_ucf_ctrl_model (.clk(clk), .rst(rst), .go_desc(go_desc),
      .go_setup(go_setup), .desc_hazard(hz), .setup_arrival(sa));
   // ***************
   // bus and checks
   // ***************
   task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.we <= 1'b1;
      @(posedge clk);
      bus.we <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      bus.addr <= a;
      bus.re <= 1'b1;
      @(posedge clk);
      bus.re <= 1'b0;
      #1;
      got = rdata;
   endtask
   // one pulse of {cause, go_setup, go_desc}, then let it settle
   task automatic kick(logic [3:0] w);
      @(posedge clk);
      {cause, go_setup, go_desc} <= w;
      @(posedge clk);
      {cause, go_setup, go_desc} <= 4'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic wait_irq(int lim);
      for (int k = 0; k < lim && irq !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #300000;
      n_errors++;
      give_verdict();
   end
   initial begin
      bus = '0;
      rst = 1'b1;
      lock = 1'b1;
      {cause, go_setup, go_desc} = 4'h0;
      fls_low = 2'h0;
      void'($urandom(66));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_CMD);
      chk("cmd reset", 32'h0, got);
      for (int i = 0; i < 24; i++) begin
         d = $urandom();
         d[23:16] = (i == 0) ? 8'h00 : (i < 7) ? 8'h01 << (i - 1) : d[23:16];
         if (d[11] && d[9:8] == 2'h0) d[9:8] = 2'h1;
         fls_low <= d[3:2];
         wr(OFS_CMD, d);
         wr(8'h0C, ~d);
         rd(OFS_CMD);
         chk("cmd", d & 32'h00FF_E800, got);
         chk("fls", {d[15], d[3:2]}, fls);
         chk("park", d[11], cmd.park_mode_enable);
         rd(8'h0C);
         chk("unmapped", 32'h0, got);
      end
      wr(OFS_MASK, 32'hC);
      wr(OFS_STATUS, 32'hF);
      wr(OFS_CMD, 32'h6000);
      kick(4'h1);
      rd(OFS_CMD);
      chk("desc sem", 32'h2000, got);
      kick(4'h2);
      rd(OFS_CMD);
      chk("setup locked", 32'h2000, got);
      lock <= 1'b0;
      kick(4'h2);
      rd(OFS_CMD);
      chk("setup sem", 32'h0, got);
      rd(OFS_STATUS);
      chk("status", 32'hC, got);
      chk("irq", 1, irq);
      wr(OFS_STATUS, 32'hC);
      repeat (3) @(posedge clk);
      #1;
      chk("irq clear", 0, irq);
      kick(4'h4);
      chk("irq masked", 0, irq);
      wr(OFS_MASK, 32'h3);
      wait_irq(4);
      chk("irq unmask", 1, irq);
      // threshold points are spaced N microframes, spacing itself is asserted
      for (int j = 0; j < 2; j++) begin
         d = j ? 32'h0020_0000 : 32'h0002_0000;
         wr(OFS_CMD, d);
         repeat (3) begin
            wr(OFS_STATUS, 32'h3);
            repeat (3) @(posedge clk);
            kick({2'($urandom_range(1, 2)), 2'h0});
            wait_irq(d[23:16] * MF + 4);
            chk("irq thr", 1, irq);
         end
      end
      give_verdict();
   end
endmodule // ucf_usb_command_tb
bind ucf_usb_command ucf_usb_command_checker #(.MFRAME_CLKS(MFRAME_CLKS)) u_chk (
   .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .frame_list_size_low(frame_list_size_low),
   .cmd(cmd), .frame_list_size(frame_list_size), .irq(irq));
`default_nettype wire
